// file: hdl/cfg_check_pkg.sv
// Constants shared by the configuration memory integrity checker
package cfg_check_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 5;
  localparam int MEM_WORDS = 24;
  // Word addresses of the user page
  localparam logic [4:0] ADDR_FIRST = 5'h00;
  localparam logic [4:0] ADDR_LAST_SIGNED = 5'h16;
  localparam logic [4:0] ADDR_SIGNATURE = 5'h17;
  localparam logic [4:0] ADDR_SETUP = 5'h10;
  // Signature engine
  localparam logic [15:0] SIG_SEED = 16'hffff;
  localparam logic [15:0] SIG_POLY = 16'h8005;
  localparam logic [15:0] MEM_RESET = 16'h0000;
  localparam logic [3:0] BIT_LAST = 4'hf;
  // Shift cycles of one check: 23 words of 16 bits
  localparam logic [8:0] CHECK_CYCLES = 9'h170;
  // Setup word field positions
  localparam int COARSE_LO = 6;
  localparam int FINE_LO = 8;
  localparam int SHIFT_LO = 10;
  localparam int TSEG_LO = 13;
  localparam logic [1:0] TSEG_FACTORY = 2'h0;
  // Factory temperature split used for segmentation code 00
  localparam logic [4:0] TSEG_FACTORY_COARSE = 5'h0c;
  localparam logic [2:0] TSEG_FACTORY_FINE = 3'h4;
endpackage

// file: hdl/cfg_word_mem.sv
// Nonvolatile word store with registered read data
`timescale 1ns/1ps
module cfg_word_mem (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [4:0] rd_addr,
  output logic [15:0] rd_data
);
  import cfg_check_pkg::*;

  // Blank store reads as zeros, so a fresh part fails its first signature check
  logic [15:0] mem [0:23] = '{default: MEM_RESET};
  logic [15:0] rd_q;

  // Write port and registered read port
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_q <= mem[rd_addr];
  end
  assign rd_data = rd_q;
endmodule

// file: hdl/cfg_integrity_check.sv
// Configuration loader: shadow RAM, program, power-up signature check
//
// Operation
// [R1] Fine-resolution field selects 0/2/4/6 second-stage bits
// [R2] Input shift field offsets window by (code+1)/16
// [R3] Temperature split: factory, 16/0, 10/6, 12/4
// [R4] Word 17h stores the user page signature
// [R5] Power-up recomputes signature and compares it
// [R6] Polynomial x^16 + x^15 + x^2 + 1
// [R7] Signature register preset to ffff
// [R8] Master writes identification to shadow first
// [R9] Program copies whole shadow into nonvolatile
// [R10] Master keeps setup unchanged during calibration
// [R11] Coarse field selects 10/12/14/16 first-stage bits
// [R12] Check words 00h-16h ascending, MSB first
// [R13] Mismatch sets a sticky integrity error flag
`timescale 1ns/1ps
module cfg_integrity_check
  import cfg_check_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic shadow_wr,
  input wire logic [cfg_check_pkg::ADDR_W-1:0] shadow_addr,
  input wire logic [cfg_check_pkg::WORD_W-1:0] shadow_data,
  input wire logic program_req,
  input wire logic err_clear,
  output logic busy,
  output logic check_done,
  output logic integrity_err,
  output logic [15:0] stored_signature,
  output logic [15:0] computed_signature,
  output logic [4:0] coarse_bits,
  output logic [2:0] fine_bits,
  output logic [3:0] shift_sixteenths,
  output logic [4:0] temp_coarse_bits,
  output logic [2:0] temp_fine_bits
);
  import cfg_check_pkg::*;

  typedef enum logic [2:0] {S_CLEAR, S_CHECK, S_FINISH, S_IDLE, S_PROG} state_t;

  // ----------------------------------------------------------------
  // Shadow RAM (registers) and nonvolatile store
  // ----------------------------------------------------------------
  logic [15:0] shadow_q [0:23];
  logic [15:0] shadow_d [0:23];
  logic [15:0] setup_q, setup_d;
  state_t state_q, state_d;
  logic [4:0] addr_q, addr_d;
  logic [3:0] bit_q, bit_d;
  logic [15:0] sig_q, sig_d, stored_q, stored_d;
  logic busy_q, done_q, err_q, busy_d, done_d, err_d;
  logic [15:0] nv_rd;
  logic nv_wr;
  logic [4:0] nv_rd_addr;

  // One LFSR step, MSB-first serial input
  function automatic logic [15:0] lfsr_step(input logic [15:0] s, input logic din);
    logic fb;
    fb = s[15] ^ din;
    lfsr_step = {s[14:0], 1'b0} ^ (fb ? SIG_POLY : 16'h0000); // see [R6]
  endfunction

  // Nonvolatile copy is written only while programming
  assign nv_wr = (state_q == S_PROG); // see [R9]
  assign nv_rd_addr = addr_d; // Look ahead so each word is ready on its first bit

  cfg_word_mem u_nv (
    .sys_clk(sys_clk),
    .wr_en(nv_wr),
    .wr_addr(addr_q),
    .wr_data(shadow_q[addr_q]),
    .rd_addr(nv_rd_addr),
    .rd_data(nv_rd)
  );

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    bit_d = bit_q;
    sig_d = sig_q;
    stored_d = stored_q;
    busy_d = busy_q;
    done_d = 1'b0;
    err_d = err_q;
    setup_d = setup_q;
    for (int i = 0; i < MEM_WORDS; i++) begin
      shadow_d[i] = shadow_q[i];
    end
    // Clear from software loses to a new mismatch
    if (err_clear) begin
      err_d = 1'b0;
    end
    unique case (state_q)
      S_CLEAR: begin
        // Registered read of word 00h lands as the first shift starts
        addr_d = ADDR_FIRST;
        bit_d = BIT_LAST;
        sig_d = SIG_SEED; // see [R7]
        busy_d = 1'b1;
        state_d = S_CHECK;
      end
      S_CHECK: begin
        // Shift the registered word bit by bit, address held meanwhile
        sig_d = lfsr_step(sig_q, nv_rd[bit_q]); // see [R5] [R12]
        shadow_d[addr_q] = nv_rd;
        if (addr_q == ADDR_SETUP) begin
          setup_d = nv_rd;
        end
        if (bit_q == 4'h0) begin
          bit_d = BIT_LAST;
          if (addr_q == ADDR_LAST_SIGNED) begin
            addr_d = ADDR_SIGNATURE; // see [R12]
            state_d = S_FINISH;
          end else begin
            addr_d = addr_q + 5'h01;
          end
        end else begin
          bit_d = bit_q - 4'h1;
        end
      end
      S_FINISH: begin
        // First cycle waits with bit_q at BIT_LAST; signature word is compared on the next
        if (bit_q == BIT_LAST) begin
          bit_d = 4'h0;
        end else begin
          stored_d = nv_rd; // see [R4]
          shadow_d[ADDR_SIGNATURE] = nv_rd;
          if (nv_rd != sig_q) begin
            err_d = 1'b1; // see [R13]
          end
          busy_d = 1'b0;
          done_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_IDLE: begin
        if (program_req) begin
          addr_d = ADDR_FIRST;
          busy_d = 1'b1;
          state_d = S_PROG;
        end else if (shadow_wr && shadow_addr <= ADDR_SIGNATURE) begin
          shadow_d[shadow_addr] = shadow_data; // see [R8]
          if (shadow_addr == ADDR_SETUP) begin
            setup_d = shadow_data; // see [R10]
          end
        end
      end
      S_PROG: begin
        // Whole shadow goes across, signature word included
        if (addr_q == ADDR_SIGNATURE) begin
          state_d = S_CLEAR; // see [R9]
        end else begin
          addr_d = addr_q + 5'h01;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= S_CLEAR;
      addr_q <= ADDR_FIRST;
      bit_q <= BIT_LAST;
      sig_q <= SIG_SEED;
      stored_q <= MEM_RESET;
      busy_q <= 1'b1;
      done_q <= 1'b0;
      err_q <= 1'b0;
      setup_q <= MEM_RESET;
      for (int i = 0; i < MEM_WORDS; i++) begin
        shadow_q[i] <= MEM_RESET;
      end
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      bit_q <= bit_d;
      sig_q <= sig_d;
      stored_q <= stored_d;
      busy_q <= busy_d;
      done_q <= done_d;
      err_q <= err_d;
      setup_q <= setup_d;
      for (int i = 0; i < MEM_WORDS; i++) begin
        shadow_q[i] <= shadow_d[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Setup word decode, registered
  // ----------------------------------------------------------------
  logic [4:0] coarse_q, coarse_d, tc_q, tc_d;
  logic [2:0] fine_q, fine_d, tf_q, tf_d;
  logic [3:0] shift_q, shift_d;

  always_comb begin
    coarse_d = 5'h0a + {2'h0, setup_q[COARSE_LO+:2], 1'b0}; // see [R11]
    fine_d = {setup_q[FINE_LO+:2], 1'b0}; // see [R1]
    shift_d = {1'b0, setup_q[SHIFT_LO+:3]} + 4'h1; // see [R2]
    unique case (setup_q[TSEG_LO+:2]) // see [R3]
      TSEG_FACTORY: begin
        tc_d = TSEG_FACTORY_COARSE;
        tf_d = TSEG_FACTORY_FINE;
      end
      2'h1: begin
        tc_d = 5'h10;
        tf_d = 3'h0;
      end
      2'h2: begin
        tc_d = 5'h0a;
        tf_d = 3'h6;
      end
      2'h3: begin
        tc_d = 5'h0c;
        tf_d = 3'h4;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      coarse_q <= 5'h0a;
      fine_q <= 3'h0;
      shift_q <= 4'h1;
      tc_q <= TSEG_FACTORY_COARSE;
      tf_q <= TSEG_FACTORY_FINE;
    end else begin
      coarse_q <= coarse_d;
      fine_q <= fine_d;
      shift_q <= shift_d;
      tc_q <= tc_d;
      tf_q <= tf_d;
    end
  end

  assign busy = busy_q;
  assign check_done = done_q;
  assign integrity_err = err_q;
  assign stored_signature = stored_q;
  assign computed_signature = sig_q;
  assign coarse_bits = coarse_q;
  assign fine_bits = fine_q;
  assign shift_sixteenths = shift_q;
  assign temp_coarse_bits = tc_q;
  assign temp_fine_bits = tf_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [8:0] chk_cnt_q, chk_cnt_d;
  // Shift cycles of a check; too long for a plain delay, so counted here
  always_comb begin
    chk_cnt_d = (state_q == S_CHECK) ? chk_cnt_q + 9'h001 : 9'h000;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      chk_cnt_q <= 9'h000;
    end else begin
      chk_cnt_q <= chk_cnt_d;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_seed_on_start: assert property (state_q == S_CLEAR |=> sig_q == SIG_SEED) // see [R7]
    else $error("signature not preset");
  a_check_length: assert property ($rose(state_q == S_FINISH) |-> chk_cnt_q == CHECK_CYCLES) // see [R12]
    else $error("check did not walk 23 words");
  a_err_sticky: assert property (err_q && !err_clear |=> err_q) // see [R13]
    else $error("error flag dropped");
  a_err_cause: assert property ($rose(err_q) |-> $past(done_d) && $past(nv_rd != sig_q)) // see [R5]
    else $error("error without mismatch");
  a_done_pulse: assert property (done_q |=> !done_q) // see [R5]
    else $error("done longer than a cycle");
  a_poly_step: assert property (state_q == S_CHECK |=>
      sig_q == ({$past(sig_q[14:0]), 1'b0} ^
      (($past(sig_q[15]) ^ $past(nv_rd[bit_q])) ? 16'h8005 : 16'h0000))) // see [R6]
    else $error("lfsr step wrong");
  a_fine_map: assert property (fine_q == {$past(setup_q[9:8]), 1'b0}) // see [R1]
    else $error("fine bits wrong");
  a_coarse_map: assert property (coarse_q >= 5'h0a && coarse_q <= 5'h10) // see [R11]
    else $error("coarse bits out of range");
  a_shift_map: assert property (shift_q == {1'b0, $past(setup_q[12:10])} + 4'h1) // see [R2]
    else $error("shift wrong");
  a_prog_length: assert property ($rose(state_q == S_PROG) |-> ##24 state_q == S_CLEAR) // see [R9]
    else $error("program length wrong");
  a_tseg_split: assert property (tc_q + {2'h0, tf_q} == 5'h10) // see [R3]
    else $error("temperature split wrong");
  c_check_ok: cover property (done_q && !err_q);
  c_check_bad: cover property (done_q && err_q);
  c_program: cover property (state_q == S_PROG ##1 state_q == S_PROG);
  c_set_clear: cover property (err_clear && err_q);
endmodule

// file: sim/cal_master.sv
// Calibration master model that fills shadow RAM and requests programming
`timescale 1ns/1ps
module cal_master (
  input wire logic sys_clk,
  input wire logic busy,
  output logic shadow_wr,
  output logic [4:0] shadow_addr,
  output logic [15:0] shadow_data,
  output logic program_req
);
  // Copy of what the device should hold after a program
  logic [15:0] image [0:22];

  initial begin
    shadow_wr = 1'b0;
    shadow_addr = 5'h00;
    shadow_data = 16'h0000;
    program_req = 1'b0;
    for (int a = 0; a < 23; a++) image[a] = 16'h0000;
  end

  // Signature the programmer stores in word 17h, MSB first over words 00h-16h
  function automatic logic [15:0] page_sig();
    logic [15:0] s;
    logic fb;
    s = 16'hffff;
    for (int a = 0; a < 23; a++) begin
      for (int b = 15; b >= 0; b--) begin
        fb = s[15] ^ image[a][b];
        s = {s[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0000);
      end
    end
    return s;
  endfunction

  // Idle is judged on the falling edge so the rising edge never races the design
  task automatic wait_idle();
    do @(negedge sys_clk); while (busy !== 1'b0);
  endtask

  // One shadow write; with idle low it is sent into a busy device on purpose
  task automatic write_word(input logic [4:0] a, input logic [15:0] d, input logic idle);
    if (idle) wait_idle();
    @(posedge sys_clk);
    shadow_wr <= 1'b1;
    shadow_addr <= a;
    shadow_data <= d;
    @(posedge sys_clk);
    // Released lines show the inverse so a stale value cannot pass as a write
    shadow_wr <= 1'b0;
    shadow_addr <= ~a;
    shadow_data <= ~d;
    if (idle && a <= 5'h16) image[a] = d;
  endtask

  // Commit the whole shadow image to nonvolatile store
  task automatic do_program();
    wait_idle();
    @(posedge sys_clk);
    program_req <= 1'b1;
    @(posedge sys_clk);
    program_req <= 1'b0;
  endtask
endmodule

// file: sim/testbench.sv
// Self-checking bench for the configuration integrity checker
`timescale 1ns/1ps
module testbench;
  import cfg_check_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic err_clear = 1'b0;
  logic shadow_wr, program_req, busy, check_done, integrity_err;
  logic [4:0] shadow_addr, coarse_bits, temp_coarse_bits;
  logic [15:0] shadow_data, stored_signature, computed_signature;
  logic [2:0] fine_bits, temp_fine_bits;
  logic [3:0] shift_sixteenths;
  logic exp_err;
  int err_count = 0;
  int n_compared = 0;

  always #12.5 sys_clk = ~sys_clk;

  cfg_integrity_check cfg_integrity_check_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .shadow_wr(shadow_wr), .shadow_addr(shadow_addr), .shadow_data(shadow_data),
    .program_req(program_req), .err_clear(err_clear), .busy(busy),
    .check_done(check_done), .integrity_err(integrity_err),
    .stored_signature(stored_signature), .computed_signature(computed_signature),
    .coarse_bits(coarse_bits), .fine_bits(fine_bits), .shift_sixteenths(shift_sixteenths),
    .temp_coarse_bits(temp_coarse_bits), .temp_fine_bits(temp_fine_bits));

  cal_master cal_master_inst (.sys_clk(sys_clk), .busy(busy), .shadow_wr(shadow_wr),
    .shadow_addr(shadow_addr), .shadow_data(shadow_data), .program_req(program_req));

  // ------------------------------
  // Checking helpers
  // ------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Bounded wait for the one-cycle end-of-check pulse
  task automatic wait_done();
    for (int i = 0; i < 1000 && check_done !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    check("check_done", {15'h0, check_done}, 16'h0001);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  // Reset defaults, then the automatic power-up check of the blank store
  task automatic t_reset();
    repeat (4) @(posedge sys_clk);
    #1;
    check("busy", {15'h0, busy}, 16'h0001);
    check("coarse", {11'h0, coarse_bits}, 16'h000a);
    check("fine", {13'h0, fine_bits}, 16'h0000);
    check("shift", {12'h0, shift_sixteenths}, 16'h0001);
    check("tcoarse", {11'h0, temp_coarse_bits}, 16'h000c);
    check("tfine", {13'h0, temp_fine_bits}, 16'h0004);
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    wait_done();
    exp_err = (cal_master_inst.page_sig() != 16'h0000);
    check("computed", computed_signature, cal_master_inst.page_sig());
    check("stored", stored_signature, 16'h0000);
    check("err", {15'h0, integrity_err}, {15'h0, exp_err});
  endtask

  // Every code of every setup field, decoded straight from the shadow write
  task automatic t_decode();
    logic [15:0] w;
    logic [4:0] tc [4] = '{5'h0c, 5'h10, 5'h0a, 5'h0c};
    logic [2:0] tf [4] = '{3'h4, 3'h0, 3'h6, 3'h4};
    for (int k = 0; k < 8; k++) begin
      w = {1'b0, 2'(k), 3'(k), 2'(k), 2'(k), 6'h00};
      cal_master_inst.write_word(ADDR_SETUP, w, 1'b1);
      repeat (3) @(posedge sys_clk);
      #1;
      check("coarse", {11'h0, coarse_bits}, 16'h000a + 16'(2 * (k % 4)));
      check("fine", {13'h0, fine_bits}, 16'(2 * (k % 4)));
      check("shift", {12'h0, shift_sixteenths}, 16'(k + 1));
      check("tcoarse", {11'h0, temp_coarse_bits}, {11'h0, tc[k % 4]});
      check("tfine", {13'h0, temp_fine_bits}, {13'h0, tf[k % 4]});
    end
  endtask

  // Whole user page written, programmed and signed again
  task automatic t_program();
    cal_master_inst.write_word(5'h00, 16'h1234, 1'b1);
    cal_master_inst.write_word(5'h01, 16'h5678, 1'b1);
    for (int a = 2; a < 23; a++) cal_master_inst.write_word(5'(a), 16'(a * 257) ^ 16'h00f0, 1'b1);
    // A wrong signature word must be caught once it is programmed
    cal_master_inst.write_word(ADDR_SIGNATURE, 16'hbeef, 1'b1);
    cal_master_inst.do_program();
    #1;
    check("busy", {15'h0, busy}, 16'h0001);
    wait_done();
    exp_err = (cal_master_inst.page_sig() != 16'hbeef);
    check("computed", computed_signature, cal_master_inst.page_sig());
    check("stored", stored_signature, 16'hbeef);
    check("err", {15'h0, integrity_err}, {15'h0, exp_err});
  endtask

  // Sticky flag clears on request; a write sent while busy is dropped
  task automatic t_sticky_refuse();
    repeat (5) @(posedge sys_clk);
    #1;
    check("err_hold", {15'h0, integrity_err}, {15'h0, exp_err});
    @(posedge sys_clk);
    err_clear <= 1'b1;
    @(posedge sys_clk);
    err_clear <= 1'b0;
    #1;
    check("err_clr", {15'h0, integrity_err}, 16'h0000);
    // Correct signature this time; the write sent while busy must be dropped
    cal_master_inst.write_word(ADDR_SIGNATURE, cal_master_inst.page_sig(), 1'b1);
    cal_master_inst.do_program();
    cal_master_inst.write_word(ADDR_SETUP, 16'h0000, 1'b0);
    wait_done();
    check("coarse_kept", {11'h0, coarse_bits},
      16'h000a + 16'(2 * cal_master_inst.image[16][7:6]));
    check("stored_ok", stored_signature, cal_master_inst.page_sig());
    check("err_again", {15'h0, integrity_err}, 16'h0000);
  endtask

  // Hang guard: the run needs about 1,270 cycles
  initial begin
    #100000;
    err_count++;
    conclude();
  end

  initial begin
    t_reset();
    t_decode();
    t_program();
    t_sticky_refuse();
    conclude();
  end
endmodule
